// file: verilog/fsq_host.sv
// Host controller driving a parallel flash: secure region, query, writes.
`timescale 1ns/1ps
module fsq_host
   import fsq_pkg::*;
#(
   parameter int POLL_MAX = 65535
) (
   // Clock, reset and clock enable.
   input  wire logic                       mclk,
   input  wire logic                       rst_n,
   input  wire logic                       clk_en,
   // Request port.
   input  wire logic                       cmd_valid,
   input  wire fsq_pkg::fsq_req_t          cmd_code,
   input  wire logic [fsq_pkg::FSQ_AW-1:0] cmd_addr,
   input  wire logic [fsq_pkg::FSQ_DW-1:0] cmd_data,
   output logic                            cmd_ready,
   // Answer port.
   output logic                            rsp_valid,
   output logic                            rsp_err,
   output logic [fsq_pkg::FSQ_DW-1:0]      rsp_data,
   // Status.
   output logic                            qry_ok,
   output logic                            sec_active,
   // Query word readback.
   input  wire logic [4:0]                 qry_raddr,
   output logic [fsq_pkg::FSQ_DW-1:0]      qry_rdata,
   // Flash pins.
   output fsq_pkg::fsq_pins_t              flash_pins,
   input  wire logic [fsq_pkg::FSQ_DW-1:0] flash_dq_in,
   input  wire logic                       flash_supply_ok
);
   import fsq_pkg::*;

   if (POLL_MAX < 1 || POLL_MAX > 65535) begin : g_chk
      $error("fsq_host POLL_MAX must lie in 1..65535");
   end

   typedef enum logic [2:0] {
      S_IDLE  = 3'b000,
      S_FETCH = 3'b001,
      S_WSET  = 3'b010,
      S_WLOW  = 3'b011,
      S_WHI   = 3'b100,
      S_RWAIT = 3'b101,
      S_RST   = 3'b110,
      S_DONE  = 3'b111
   } fsq_state_t;

   typedef struct packed {
      fsq_state_t        state;
      fsq_pins_t         pins;
      fsq_req_t          cmd;
      logic [FSQ_AW-1:0] uaddr;
      logic [FSQ_DW-1:0] udata;
      logic [4:0]        idx;
      logic [15:0]       cnt;
      logic [15:0]       polls;
      logic [FSQ_DW-1:0] s1, s2, s3, stab;
      logic              p1, p2, p3, sup_ok;
      logic              ready, rsp_valid, rsp_err, qry_ok;
      logic              sec_active, lock_pend;
      logic [FSQ_DW-1:0] rsp_data, wd1, wd2;
      logic              qwe;
      logic [4:0]        qwaddr;
      logic [FSQ_DW-1:0] qwdata;
   } fsq_st_t;

   // Pins idle high with the data bus released.
   localparam fsq_pins_t PINS_IDLE = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
      rst_n: 1'b1, dq_drive_n: 1'b1, addr: '0, dq_out: '0};
   localparam fsq_st_t ST_INIT = '{state: S_IDLE, pins: PINS_IDLE,
      cmd: REQ_READ, default: '0};

   fsq_st_t r_reg, r_next;
   fsq_op_t op;

   function automatic fsq_op_t mk(fsq_opk_t k, logic [FSQ_AW-1:0] a,
                                  logic [FSQ_DW-1:0] d);
      fsq_op_t o;
      o.kind = k;
      o.addr = a;
      o.data = d;
      return o;
   endfunction : mk

   ////////////////////////////////////////////////////////////////////////
   // Step list of every request; the two unlock writes open each
   // program, erase and region command so stray writes never count.
   function automatic fsq_op_t seq_op(fsq_req_t c, logic [4:0] i,
                                      logic [FSQ_AW-1:0] a,
                                      logic [FSQ_DW-1:0] d);
      fsq_op_t o;
      o = mk(OP_END, ANY_ADDR, '0);
      if (c == REQ_READ) begin
         if (i == 5'd0) o = mk(OP_RD, a, '0);
      end else if (c == REQ_QUERY) begin
         if (i == 5'd0) o = mk(OP_WR, QUERY_ADDR, CMD_QUERY);
         else if (int'(i) <= QRY_LEN)
            o = mk(OP_RD, QRY_BASE + FSQ_AW'(i - 5'd1), '0);
         else if (int'(i) == QRY_LEN + 1)
            o = mk(OP_WR, ANY_ADDR, CMD_RESET);
      end else if (c == REQ_HWRESET) begin
         if (i == 5'd0) o = mk(OP_RST, ANY_ADDR, '0);
      end else if (i == 5'd0 || (c == REQ_ERASE && i == 5'd3)
                   || (c == REQ_SEC_LOCK && i == 5'd5)) begin
         o = mk(OP_WR, UNL1_ADDR, UNL1_DATA);
      end else if (i == 5'd1 || (c == REQ_ERASE && i == 5'd4)
                   || (c == REQ_SEC_LOCK && i == 5'd6)) begin
         o = mk(OP_WR, UNL2_ADDR, UNL2_DATA);
      end else begin
         unique case (c)
            REQ_PROG: begin
               // Full sequence every word, never a shortcut.
               if (i == 5'd2) o = mk(OP_WR, UNL1_ADDR, CMD_PROG);
               if (i == 5'd3) o = mk(OP_WR, a, d);
               if (i == 5'd4) o = mk(OP_POLL, a, d);
            end
            REQ_ERASE: begin
               if (i == 5'd2) o = mk(OP_WR, UNL1_ADDR, CMD_ERASE);
               if (i == 5'd5) o = mk(OP_WR, a, CMD_SECT);
               if (i == 5'd6) o = mk(OP_POLL, a, ERASED);
            end
            REQ_SEC_ENTER: begin
               if (i == 5'd2) o = mk(OP_WR, UNL1_ADDR, CMD_ENTRY);
            end
            REQ_SEC_EXIT: begin
               if (i == 5'd2) o = mk(OP_WR, UNL1_ADDR, CMD_EXIT1);
               if (i == 5'd3) o = mk(OP_WR, ANY_ADDR, CMD_EXIT2);
            end
            REQ_SEC_LOCK: begin
               // Entry, protect, verify read, then exit.
               if (i == 5'd2) o = mk(OP_WR, UNL1_ADDR, CMD_ENTRY);
               if (i == 5'd3) o = mk(OP_WR, a, CMD_PROT);
               if (i == 5'd4) o = mk(OP_RD, a, '0);
               if (i == 5'd7) o = mk(OP_WR, UNL1_ADDR, CMD_EXIT1);
               if (i == 5'd8) o = mk(OP_WR, ANY_ADDR, CMD_EXIT2);
            end
            default: o = mk(OP_END, ANY_ADDR, '0);
         endcase
      end
      return o;
   endfunction : seq_op

   ////////////////////////////////////////////////////////////////////////
   // Next-state logic of the whole controller.
   always_comb begin
      r_next = r_reg;
      r_next.rsp_valid = 1'b0;
      r_next.qwe = 1'b0;
      op = seq_op(r_reg.cmd, r_reg.idx, r_reg.uaddr, r_reg.udata);
      // Pin inputs count only when the second and third stages agree.
      r_next.s1 = flash_dq_in;
      r_next.s2 = r_reg.s1;
      r_next.s3 = r_reg.s2;
      if (r_reg.s2 == r_reg.s3) r_next.stab = r_reg.s3;
      r_next.p1 = flash_supply_ok;
      r_next.p2 = r_reg.p1;
      r_next.p3 = r_reg.p2;
      if (r_reg.p2 == r_reg.p3) r_next.sup_ok = r_reg.p3;
      unique case (r_reg.state)
         S_IDLE: begin
            r_next.ready = 1'b1;
            if (cmd_valid && r_reg.ready) begin
               r_next.ready = 1'b0;
               r_next.cmd = cmd_code;
               r_next.uaddr = cmd_addr;
               r_next.udata = cmd_data;
               r_next.idx = '0;
               r_next.polls = '0;
               r_next.rsp_err = 1'b0;
               r_next.state = S_FETCH;
               if (cmd_code == REQ_QUERY) r_next.qry_ok = 1'b1;
            end
         end
         S_FETCH: begin
            if (!r_reg.sup_ok && op.kind != OP_END) begin
               r_next.rsp_err = 1'b1;
               r_next.state = S_DONE;
            end else begin
               unique case (op.kind)
                  OP_WR: begin
                     // Select and data first, output enable held high.
                     r_next.pins.addr = op.addr;
                     r_next.pins.dq_out = op.data;
                     r_next.pins.dq_drive_n = 1'b0;
                     r_next.pins.oe_n = 1'b1;
                     r_next.pins.ce_n = 1'b0;
                     r_next.state = S_WSET;
                  end
                  OP_RD, OP_POLL: begin
                     r_next.pins.addr = op.addr;
                     r_next.pins.ce_n = 1'b0;
                     r_next.pins.oe_n = 1'b0;
                     r_next.cnt = 16'(ACC_CYC - 1);
                     r_next.state = S_RWAIT;
                  end
                  OP_RST: begin
                     r_next.pins.rst_n = 1'b0;
                     r_next.cnt = 16'(RP_CYC - 1);
                     r_next.state = S_RST;
                  end
                  OP_END: r_next.state = S_DONE;
                  default: r_next.state = S_DONE;
               endcase
            end
         end
         S_WSET: begin
            r_next.pins.we_n = 1'b0;
            r_next.cnt = 16'(WP_CYC - 1);
            r_next.state = S_WLOW;
         end
         S_WLOW: begin
            if (r_reg.cnt == '0) begin
               r_next.pins.we_n = 1'b1;
               r_next.wd1 = r_reg.pins.dq_out;
               r_next.wd2 = r_reg.wd1;
               // Track region mode and a lock awaiting its exit.
               if (r_reg.pins.dq_out == CMD_ENTRY && r_reg.wd1 == UNL2_DATA)
                  r_next.sec_active = 1'b1;
               if (r_reg.pins.dq_out == CMD_PROT && r_reg.sec_active)
                  r_next.lock_pend = 1'b1;
               if (r_reg.pins.dq_out == CMD_EXIT2
                   && r_reg.wd1 == CMD_EXIT1) begin
                  r_next.sec_active = 1'b0;
                  r_next.lock_pend = 1'b0;
               end
               r_next.state = S_WHI;
            end else begin
               r_next.cnt = r_reg.cnt - 16'd1;
            end
         end
         S_WHI: begin
            r_next.pins.ce_n = 1'b1;
            r_next.pins.dq_drive_n = 1'b1;
            r_next.idx = r_reg.idx + 5'd1;
            r_next.state = S_FETCH;
         end
         S_RWAIT: begin
            if (r_reg.cnt == '0) begin
               r_next.pins.ce_n = 1'b1;
               r_next.pins.oe_n = 1'b1;
               r_next.state = S_FETCH;
               if (op.kind == OP_RD) begin
                  r_next.rsp_data = r_reg.stab;
                  r_next.idx = r_reg.idx + 5'd1;
                  if (r_reg.cmd == REQ_QUERY) begin
                     // Check each query word against the table.
                     r_next.qwe = 1'b1;
                     r_next.qwaddr = r_reg.idx - 5'd1;
                     r_next.qwdata = r_reg.stab;
                     if (r_reg.stab != QRY_EXP[r_reg.idx - 5'd1])
                        r_next.qry_ok = 1'b0;
                  end
               end else if (r_reg.stab == op.data) begin
                  r_next.rsp_data = r_reg.stab;
                  r_next.idx = r_reg.idx + 5'd1;
               end else if (int'(r_reg.polls) >= POLL_MAX) begin
                  r_next.rsp_data = r_reg.stab;
                  r_next.rsp_err = 1'b1;
                  r_next.state = S_DONE;
               end else begin
                  r_next.polls = r_reg.polls + 16'd1;
               end
            end else begin
               r_next.cnt = r_reg.cnt - 16'd1;
            end
         end
         S_RST: begin
            if (r_reg.cnt == '0) begin
               r_next.pins.rst_n = 1'b1;
               r_next.sec_active = 1'b0;
               r_next.lock_pend = 1'b0;
               r_next.idx = r_reg.idx + 5'd1;
               r_next.state = S_FETCH;
            end else begin
               r_next.cnt = r_reg.cnt - 16'd1;
            end
         end
         S_DONE: begin
            r_next.rsp_valid = 1'b1;
            r_next.ready = 1'b1;
            r_next.state = S_IDLE;
         end
      endcase
   end

   // State register; reset loads the idle pins with the write strobe high.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         r_reg <= ST_INIT;
      end else if (clk_en) begin
         r_reg <= r_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Query word store and outputs.
   fsq_qmem #(.W(FSQ_DW), .DEPTH(QRY_LEN), .AW(5)) u_qmem (
      .mclk    (mclk),
      .clk_en  (clk_en),
      .wr_en   (r_reg.qwe),
      .wr_addr (r_reg.qwaddr),
      .wr_data (r_reg.qwdata),
      .rd_addr (qry_raddr),
      .rd_data (qry_rdata)
   );

   assign flash_pins = r_reg.pins;
   assign cmd_ready  = r_reg.ready;
   assign rsp_valid  = r_reg.rsp_valid;
   assign rsp_err    = r_reg.rsp_err;
   assign rsp_data   = r_reg.rsp_data;
   assign qry_ok     = r_reg.qry_ok;
   assign sec_active = r_reg.sec_active;

   ////////////////////////////////////////////////////////////////////////
   // Checks on the driven pins and sequences.
   sequence s_query_end;
      r_reg.rsp_valid && r_reg.cmd == REQ_QUERY && !r_reg.rsp_err;
   endsequence

   a_write_strobe_qual: assert property (
      @(posedge mclk) disable iff (!rst_n)
      !r_reg.pins.we_n |-> !r_reg.pins.ce_n && r_reg.pins.oe_n
         && !r_reg.pins.dq_drive_n)
      else $error("write strobe low without select or with oe low");
   a_read_no_write: assert property (
      @(posedge mclk) disable iff (!rst_n)
      !r_reg.pins.oe_n |-> r_reg.pins.we_n && r_reg.pins.dq_drive_n)
      else $error("output enable low while writing");
   a_query_cmd_addr: assert property (
      @(posedge mclk) disable iff (!rst_n)
      $fell(r_reg.pins.we_n) && r_reg.pins.dq_out == CMD_QUERY
         |-> r_reg.pins.addr == QUERY_ADDR)
      else $error("query command at wrong address");
   a_prog_full_seq: assert property (
      @(posedge mclk) disable iff (!rst_n)
      $rose(r_reg.pins.we_n) && r_reg.wd1 == CMD_PROG
         |-> r_reg.wd2 == UNL2_DATA)
      else $error("program command without unlock cycles");
   a_lock_in_region: assert property (
      @(posedge mclk) disable iff (!rst_n)
      $rose(r_reg.pins.we_n) && r_reg.wd1 == CMD_PROT
         |-> r_reg.sec_active && r_reg.lock_pend)
      else $error("protect step outside the region");
   a_exit_after_lock: assert property (
      @(posedge mclk) disable iff (!rst_n)
      $rose(r_reg.ready) |-> !r_reg.lock_pend)
      else $error("request ended with a lock awaiting exit");
   a_query_reset_out: assert property (
      @(posedge mclk) disable iff (!rst_n)
      s_query_end |-> r_reg.wd1 == CMD_RESET && r_reg.pins.we_n)
      else $error("query finished without the reset command");

endmodule : fsq_host

// file: include/fsq_pkg.sv
// Shared constants and types of the flash secure-region and query host.
package fsq_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Widths and clock.
   localparam int FSQ_AW = 21;
   localparam int FSQ_DW = 16;
   localparam int CLK_NS = 4;

   // Pin timing in nanoseconds; least times round up to whole cycles.
   localparam int T_WP_NS  = 25;
   localparam int T_ACC_NS = 70;
   localparam int T_RP_NS  = 500;
   localparam int SYNC_CYC = 3;
   localparam int WP_CYC   = (T_WP_NS + CLK_NS - 1) / CLK_NS;
   localparam int ACC_CYC  = (T_ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC;
   localparam int RP_CYC   = (T_RP_NS + CLK_NS - 1) / CLK_NS;

   ////////////////////////////////////////////////////////////////////////
   // Command cycle addresses and data.
   localparam logic [FSQ_AW-1:0] UNL1_ADDR  = 21'h000555;
   localparam logic [FSQ_AW-1:0] UNL2_ADDR  = 21'h0002AA;
   localparam logic [FSQ_AW-1:0] QUERY_ADDR = 21'h000055;
   localparam logic [FSQ_AW-1:0] QRY_BASE   = 21'h000010;
   localparam logic [FSQ_AW-1:0] ANY_ADDR   = 21'h000000;
   localparam logic [FSQ_DW-1:0] UNL1_DATA  = 16'h00AA;
   localparam logic [FSQ_DW-1:0] UNL2_DATA  = 16'h0055;
   localparam logic [FSQ_DW-1:0] CMD_PROG   = 16'h00A0;
   localparam logic [FSQ_DW-1:0] CMD_ERASE  = 16'h0080;
   localparam logic [FSQ_DW-1:0] CMD_SECT   = 16'h0030;
   localparam logic [FSQ_DW-1:0] CMD_ENTRY  = 16'h0088;
   localparam logic [FSQ_DW-1:0] CMD_EXIT1  = 16'h0090;
   localparam logic [FSQ_DW-1:0] CMD_EXIT2  = 16'h0000;
   localparam logic [FSQ_DW-1:0] CMD_RESET  = 16'h00F0;
   localparam logic [FSQ_DW-1:0] CMD_QUERY  = 16'h0098;
   localparam logic [FSQ_DW-1:0] CMD_PROT   = 16'h0060;
   localparam logic [FSQ_DW-1:0] ERASED     = 16'hFFFF;

   ////////////////////////////////////////////////////////////////////////
   // Query table expected from the device, word offsets 10h to 26h.
   localparam int QRY_LEN = 23;
   localparam logic [FSQ_DW-1:0] QRY_EXP [0:QRY_LEN-1] = '{
      16'h0051, 16'h0052, 16'h0059, 16'h0002, 16'h0000, 16'h0040,
      16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0027,
      16'h0036, 16'h0000, 16'h0000, 16'h0004, 16'h0000, 16'h000A,
      16'h0000, 16'h0005, 16'h0000, 16'h0004, 16'h0000};

   ////////////////////////////////////////////////////////////////////////
   // Requests, sequencer operations and pin bundle.
   typedef enum logic [2:0] {
      REQ_READ      = 3'b000,
      REQ_PROG      = 3'b001,
      REQ_ERASE     = 3'b010,
      REQ_SEC_ENTER = 3'b011,
      REQ_SEC_EXIT  = 3'b100,
      REQ_SEC_LOCK  = 3'b101,
      REQ_QUERY     = 3'b110,
      REQ_HWRESET   = 3'b111
   } fsq_req_t;

   typedef enum logic [2:0] {
      OP_WR   = 3'b000,
      OP_RD   = 3'b001,
      OP_POLL = 3'b010,
      OP_RST  = 3'b011,
      OP_END  = 3'b100
   } fsq_opk_t;

   typedef struct packed {
      fsq_opk_t          kind;
      logic [FSQ_AW-1:0] addr;
      logic [FSQ_DW-1:0] data;
   } fsq_op_t;

   typedef struct packed {
      logic              ce_n;
      logic              oe_n;
      logic              we_n;
      logic              rst_n;
      logic              dq_drive_n;
      logic [FSQ_AW-1:0] addr;
      logic [FSQ_DW-1:0] dq_out;
   } fsq_pins_t;

endpackage : fsq_pkg

// file: verilog/fsq_qmem.sv
// Small memory that keeps the query words read back from the device.
`timescale 1ns/1ps
module fsq_qmem #(
   parameter int W     = 16,
   parameter int DEPTH = 23,
   parameter int AW    = 5
) (
   // Clock.
   input  wire logic          mclk,
   input  wire logic          clk_en,
   // Write port.
   input  wire logic          wr_en,
   input  wire logic [AW-1:0] wr_addr,
   input  wire logic [W-1:0]  wr_data,
   // Read port.
   input  wire logic [AW-1:0] rd_addr,
   output logic      [W-1:0]  rd_data
);

   logic [W-1:0] mem [0:DEPTH-1];

   if (DEPTH > (1 << AW)) begin : g_chk
      $error("fsq_qmem depth does not fit the address width");
   end

   // Storage and registered read; words outside the depth read zero.
   always_ff @(posedge mclk) begin
      if (clk_en) begin
         if (wr_en && (int'(wr_addr) < DEPTH)) begin
            mem[wr_addr] <= wr_data;
         end
         if (int'(rd_addr) < DEPTH) begin
            rd_data <= mem[rd_addr];
         end else begin
            rd_data <= '0;
         end
      end
   end

endmodule : fsq_qmem

// file: testbench/fsq_flash_model.sv
// Behavioural flash device that answers the host's strobes.
`timescale 1ns/1ps
module fsq_flash_model
   import fsq_pkg::*;
#(
   // One for a part locked at shipment, zero for a customer part.
   parameter bit FACTORY_LOCKED = 1'b0
) (
   // Pins from the host.
   input  wire fsq_pkg::fsq_pins_t    pins,
   input  wire logic                  supply_ok,
   // Data pins back to the host.
   output logic [fsq_pkg::FSQ_DW-1:0] dq
);
   logic [FSQ_DW-1:0] arr [int];
   logic [FSQ_DW-1:0] sec [int];
   logic [FSQ_DW-1:0] last_reg = 16'h0000;
   int mode = 0;  // Array 0, query 1, region 2; starts in array reads.
   int prev = 0;
   int step = 0;
   bit locked = FACTORY_LOCKED, prog = 0, ers = 0, ext = 0;

   // Factory-locked parts carry a serial number in the lowest words.
   initial begin
      if (FACTORY_LOCKED) begin
         for (int i = 0; i < 8; i++) sec[i] = 16'h5A00 | 16'(i);
      end
   end

   // One accepted write cycle moves the command state.
   task automatic cmd(input int a, input logic [FSQ_DW-1:0] d);
      if (prog) begin
         if (mode != 2) arr[a] = d;
         else if (!locked) sec[a] = d;
         prog = 0;
      end else if (ext) begin
         ext = 0;
         if (d == CMD_EXIT2) mode = 0;
      end else if (mode == 2 && step == 0 && d == CMD_PROT) locked = 1;
      else if (step == 0 && a == 'h55 && d == CMD_QUERY && mode != 1
               && !ers) begin
         prev = mode;
         mode = 1;
      end else if (d == CMD_RESET) begin
         mode = (mode == 1) ? prev : mode;
         step = 0;
      end else if (step == 0) step = int'(a == 'h555 && d == UNL1_DATA);
      else if (step == 1) step = (a == 'h2AA && d == UNL2_DATA) ? 2 : 0;
      else begin
         step = 0;
         if (ers && d == CMD_SECT) begin
            if (mode != 2) arr[a] = ERASED;
            else if (!locked) sec.delete(a);
         end
         ers = (d == CMD_ERASE);
         prog = (d == CMD_PROG);
         ext = (d == CMD_EXIT1);
         if (d == CMD_ENTRY) mode = 2;
      end
   endtask : cmd

   // Word seen on the data pins for an address in the current mode.
   function automatic logic [FSQ_DW-1:0] rd(input int a);
      if (mode == 1) return (a >= 16 && a < 39) ? QRY_EXP[a-16] : 16'h0000;
      if (mode == 2) return sec.exists(a) ? sec[a] : ERASED;
      return arr.exists(a) ? arr[a] : ERASED;
   endfunction : rd

   // Writes count only with select and strobe low, output enable high.
   always @(posedge pins.we_n) begin
      if (!pins.ce_n && pins.oe_n && supply_ok) cmd(int'(pins.addr), pins.dq_out);
   end

   // Lockout or a reset pulse drops back to array reads.
   always @(negedge supply_ok or negedge pins.rst_n) begin
      mode = 0;
      step = 0;
      prog = 0;
      ers = 0;
      ext = 0;
   end

   // A released bus shows the inverse of the last word, never a copy.
   always @(posedge pins.oe_n) last_reg = rd(int'(pins.addr));
   always @(pins, mode, last_reg) begin
      dq = (pins.ce_n || pins.oe_n) ? ~last_reg : rd(int'(pins.addr));
   end
endmodule : fsq_flash_model

// file: testbench/tb.sv
// Self-checking bench for the flash host against the device model.
`timescale 1ns/1ps
module tb;
   import fsq_pkg::*;
   logic mclk = 0, rst_n = 0, cmd_valid = 0, supply_ok = 1, clk_en = 1;
   logic cmd_ready, rsp_valid, rsp_err, qry_ok, sec_active;
   fsq_req_t cmd_code = REQ_READ;
   logic [FSQ_AW-1:0] cmd_addr = 21'h000000, a;
   logic [FSQ_DW-1:0] cmd_data = 16'h0000, rsp_data, qry_rdata, dq, x;
   logic [4:0] qry_raddr = 5'h00;
   fsq_pins_t pins;
   logic [18:0] exq [$];  // Check err, check data, err, data.
   int miscompares = 0, tests_run = 0, cyc = 0;
   logic [31:0] lfsr = 32'h5D6FF908;

   initial forever #2 mclk = ~mclk;

   fsq_host #(.POLL_MAX(8)) fsq_host_i (.mclk(mclk), .rst_n(rst_n),
      .clk_en(clk_en), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
      .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_ready(cmd_ready),
      .rsp_valid(rsp_valid), .rsp_err(rsp_err), .rsp_data(rsp_data),
      .qry_ok(qry_ok), .sec_active(sec_active), .qry_raddr(qry_raddr),
      .qry_rdata(qry_rdata), .flash_pins(pins), .flash_dq_in(dq),
      .flash_supply_ok(supply_ok));
   fsq_flash_model fsq_flash_model_i (.pins(pins), .supply_ok(supply_ok),
      .dq(dq));

   function automatic logic [31:0] nxt(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : nxt

   task automatic cmp(input string n, input logic [15:0] e, g);
      tests_run++;
      if (g !== e) begin
         miscompares++;
         $display("FAIL %s expected %h seen %h", n, e, g);
      end
   endtask : cmp

   task automatic results;
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : results

   // Presents one request, then waits until its answer was checked.
   task automatic req(input fsq_req_t c, input logic [20:0] ad,
                      input logic [15:0] d, input logic [18:0] e);
      exq.push_back(e);
      @(negedge mclk);
      cmd_valid = 1;
      cmd_code = c;
      cmd_addr = ad;
      cmd_data = d;
      do @(posedge mclk); while (cmd_ready !== 1'b1 || clk_en !== 1'b1);
      @(negedge mclk);
      cmd_valid = 0;
      while (exq.size() != 0) @(negedge mclk);
   endtask : req

   // Each answer is held against the oldest expectation, mid-cycle.
   always @(negedge mclk) begin : mon
      logic [18:0] e;
      if (rsp_valid === 1'b1) begin
         e = (exq.size() != 0) ? exq.pop_front() : 19'h7FFFF;
         if (e[18]) cmp("rsp_err", {15'h0, e[16]}, {15'h0, rsp_err});
         if (e[17]) cmp("rsp_data", e[15:0], rsp_data);
      end
   end

   // Hang guard.
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         results();
      end
   end

   initial begin
      repeat (20) @(posedge mclk);
      @(negedge mclk) rst_n = 1;
      repeat (8) @(negedge mclk);
      req(REQ_QUERY, ANY_ADDR, 16'h0, {3'b110, QRY_EXP[22]});
      cmp("qry_ok", 16'h0001, {15'h0, qry_ok});
      for (int i = 0; i < 24; i++) begin
         qry_raddr = 5'(i);
         repeat (2) @(negedge mclk);
         cmp("qry_rdata", (i < 23) ? QRY_EXP[i] : 16'h0, qry_rdata);
      end
      req(REQ_READ, 21'h10, 16'h0, {3'b110, ERASED});
      $display("query test done");
      for (int i = 0; i < 4; i++) begin
         lfsr = nxt(lfsr);
         a = lfsr[20:0];
         x = lfsr[31:16];
         req(REQ_PROG, a, x, {3'b110, x});
         req(REQ_READ, a, 16'h0, {3'b110, x});
         req(REQ_ERASE, a, 16'h0, {3'b110, ERASED});
         req(REQ_READ, a, 16'h0, {3'b110, ERASED});
      end
      $display("program erase test done");
      req(REQ_SEC_ENTER, ANY_ADDR, 16'h0, {3'b100, 16'h0});
      cmp("sec_active", 16'h1, {15'h0, sec_active});
      req(REQ_PROG, 21'h3, x, {3'b110, x});
      req(REQ_READ, 21'h3, 16'h0, {3'b110, x});
      req(REQ_SEC_LOCK, 21'h3, 16'h0, {3'b110, x});
      cmp("sec_active", 16'h0, {15'h0, sec_active});
      req(REQ_SEC_ENTER, ANY_ADDR, 16'h0, {3'b100, 16'h0});
      req(REQ_PROG, 21'h3, ~x, {3'b111, x});
      req(REQ_HWRESET, ANY_ADDR, 16'h0, {3'b100, 16'h0});
      cmp("sec_active", 16'h0, {15'h0, sec_active});
      req(REQ_READ, 21'h3, 16'h0, {3'b110, ERASED});
      $display("region test done");
      supply_ok = 0;
      repeat (8) @(negedge mclk);
      req(REQ_READ, ANY_ADDR, 16'h0, {3'b101, 16'h0});
      supply_ok = 1;
      repeat (8) @(negedge mclk);
      req(REQ_READ, ANY_ADDR, 16'h0, {3'b110, ERASED});
      $display("lockout test done");
      // A frozen controller leaves a waiting request untaken.
      clk_en = 0;
      fork
         req(REQ_READ, 21'h10, 16'h0, {3'b110, ERASED});
         begin
            repeat (12) @(negedge mclk);
            cmp("ce_n", 16'h1, {15'h0, pins.ce_n});
            cmp("we_n", 16'h1, {15'h0, pins.we_n});
            cmp("rsp_valid", 16'h0, {15'h0, rsp_valid});
            clk_en = 1;
         end
      join
      $display("clock enable test done");
      results();
   end
endmodule : tb
